// File: bench/far_side.sv
// far-side model: reset pin source, supply comparator, usb host, slow osc
// assumes bench requests change just after the rising clock edge
`timescale 1ns/1ps
module far_side (
  input wire logic pin_lo,
  input wire logic sup_lo,
  input wire logic bus_rst,
  input wire logic tick_en,
  output logic rst_pin_n,
  output logic supply_low,
  output logic usb_bus_reset,
  output logic slow_tick
);
  // ----------------------------------------
  // line levels
  // ----------------------------------------
  assign rst_pin_n = ~pin_lo;
  assign supply_low = sup_lo;
  assign usb_bus_reset = bus_rst;
  assign slow_tick = tick_en;
endmodule

// File: bench/reset_sources_test.sv
// self-checking bench for the reset sequencer
// assumes short release and filter counts set by parameter
`timescale 1ns/1ps
module reset_sources_test;
  import rst_seq_pkg::*;
  localparam int REL = 8;
  localparam int PCY = 3;
  localparam int SCY = 3;
  logic clk = 1'h0, rst = 1'h1;
  logic pin_lo = 1'h0, sup_lo = 1'h0, bus_rst = 1'h0, tick_en = 1'h0;
  logic dis_f = 1'h0, dbg_f = 1'h0, osc_f = 1'h0, mon_en = 1'h0;
  logic usb_en = 1'h0, usb_ce = 1'h0, wen = 1'h0, wmode = 1'h0;
  logic kick = 1'h0, acmp = 1'h0;
  logic [2:0] div = 3'h0;
  logic [3:0] sel = 4'h0;
  port_ctl_s pc = '0, pd = '0;
  logic rpn, slo, ubr, tck, core_rst, fault, warn, irq, wpulse, osc_amp;
  pin_mode_e pmode;
  port_pad_s padc, padd;
  int n_fail = 0, num_checks = 0, cyc = 0, n;
  // ----------------------------------------
  // clock, timeout, instances
  // ----------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      conclude();
    end
  end
  far_side FS (.pin_lo(pin_lo), .sup_lo(sup_lo), .bus_rst(bus_rst),
    .tick_en(tick_en), .rst_pin_n(rpn), .supply_low(slo),
    .usb_bus_reset(ubr), .slow_tick(tck));
  reset_sources #(.REL_CYC(REL), .PIN_CYC(PCY), .SUP_CYC(SCY)) DUT (
    .CLK_SYS(clk), .RST(rst), .RST_PIN_N(rpn), .RST_PIN_DIS_FUSE(dis_f),
    .DEBUG_EN_FUSE(dbg_f), .OSC_OUT_FUSE(osc_f), .SUPPLY_MON_EN(mon_en),
    .SUPPLY_LOW(slo), .USB_EN(usb_en), .USB_RST_CORE_EN(usb_ce),
    .USB_BUS_RESET(ubr), .SLOW_OSC_TICK(tck), .WDT_DIV_SEL(div),
    .WDT_PERIOD_SEL(sel), .WDT_EN(wen), .WDT_RST_MODE(wmode),
    .WDT_KICK(kick), .ACMP_IN_USE(acmp), .PORT_C_CTL(pc),
    .PORT_D_CTL(pd), .CORE_RST(core_rst), .SUPPLY_FAULT(fault),
    .WDT_EARLY_WARN(warn), .WDT_IRQ(irq), .WDT_RST_PULSE(wpulse),
    .RST_PIN_MODE(pmode), .OSC_AMP_EN(osc_amp), .PORT_C_PAD(padc),
    .PORT_D_PAD(padd));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int e, input int tol);
    chk((got >= e - tol && got <= e + tol) ? e : got, e);
  endtask
  function automatic logic probe(input int w);
    case (w)
      0: return warn;
      1: return irq;
      2: return wpulse;
      default: return ~core_rst;
    endcase
  endfunction
  task automatic meas(input int w, input int lim, output int k);
    k = 0;
    while (probe(w) !== 1'h1 && k < lim) begin
      step(1);
      k++;
    end
  endtask
  task automatic kick_wdt;
    kick = 1'h1;
    step(1);
    kick = 1'h0;
  endtask
  function automatic logic [7:0] blk(input logic a);
    return a ? 8'h06 : 8'h00;
  endfunction
  function automatic logic [7:0] cblk(input logic osc, input logic gp);
    return {6'h00, ~gp, osc};
  endfunction
  task automatic conclude;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hff20));
    step(4);
    rst = 1'h0;
    chk(padd.oe_n, 8'hff);
    chk(padc.oe_n, 8'hff);
    meas(3, 40, n);
    near(n, REL + 1, 2);
    pin_lo = 1'h1;
    step(PCY - 1);
    pin_lo = 1'h0;
    step(3);
    chk(core_rst, 1'h0);
    pin_lo = 1'h1;
    step(PCY + 3);
    chk(core_rst, 1'h1);
    chk(padd.oe_n, 8'hff);
    chk(padc.oe_n, 8'hff);
    chk(padc.pull_en, 8'h00);
    pin_lo = 1'h0;
    meas(3, 40, n);
    near(n, REL + 1, 2);
    mon_en = 1'h1;
    sup_lo = 1'h1;
    step(SCY - 1);
    sup_lo = 1'h0;
    step(3);
    chk(fault, 1'h0);
    sup_lo = 1'h1;
    step(SCY + 1);
    chk(fault, 1'h1);
    chk(core_rst, 1'h1);
    sup_lo = 1'h0;
    meas(3, 40, n);
    near(n, REL + 1, 2);
    mon_en = 1'h0;
    sup_lo = 1'h1;
    step(SCY + 3);
    chk(fault, 1'h0);
    sup_lo = 1'h0;
    step(REL + 4);
    for (int i = 0; i < 4; i++) begin
      {usb_en, usb_ce} = 2'(i);
      bus_rst = 1'h1;
      step(2);
      chk(core_rst, 1'(i == 3));
      bus_rst = 1'h0;
      step(REL + 4);
    end
    for (int i = 0; i < 8; i++) begin
      {dbg_f, dis_f, osc_f} = 3'(i);
      step(1);
      chk(pmode, dbg_f ? PIN_DEBUG : (dis_f ? PIN_GPIO : PIN_RESET));
      chk(osc_amp, osc_f);
    end
    {dbg_f, dis_f, osc_f} = 3'h0;
    for (int i = 0; i < 6; i++) begin
      pd = port_ctl_s'(24'($urandom));
      pc = port_ctl_s'(24'($urandom));
      {dis_f, osc_f} = 2'($urandom);
      if (i == 0) pd.dir = 8'h00;
      acmp = 1'(i);
      step(2);
      chk(padd.oe_n, 8'(~pd.dir | blk(acmp)));
      chk(padd.pull_en, pd.pull & ~pd.dir & ~blk(acmp));
      chk(padd.out & ~blk(acmp), pd.data & ~blk(acmp));
      chk(padc.oe_n, 8'(~pc.dir | cblk(osc_f, dis_f)));
      chk(padc.pull_en, pc.pull & ~pc.dir & ~cblk(osc_f, dis_f));
      chk(padc.out, pc.data);
    end
    {dis_f, osc_f} = 2'h0;
    tick_en = 1'h1;
    wen = 1'h1;
    wmode = 1'h1;
    sel = 4'ha;
    kick_wdt();
    meas(0, 4200, n);
    chk(n, 4200);
    sel = 4'h0;
    kick_wdt();
    meas(0, 5000, n);
    near(n, 2048, 2);
    meas(2, 5000, n);
    near(n, 2048, 2);
    step(1);
    chk(wpulse, 1'h0);
    chk(core_rst, 1'h1);
    wen = 1'h0;
    meas(3, 40, n);
    near(n, REL, 2);
    wmode = 1'h0;
    wen = 1'h1;
    sel = 4'h1;
    kick_wdt();
    meas(0, 9000, n);
    near(n, 4096, 2);
    meas(1, 9000, n);
    near(n, 4096, 2);
    chk(core_rst, 1'h0);
    div = 3'h5;
    sel = 4'h0;
    kick_wdt();
    meas(0, 23000, n);
    near(n, 2048 * 11, 12);
    conclude();
  end
endmodule

// File: logic/reset_sources.sv
// reset source collection, release delay, watchdog time-out
// and reset-time pin control; one clock, synchronous inputs
`timescale 1ns/1ps
module reset_sources import rst_seq_pkg::*; #(
  parameter int REL_CYC = RELEASE_CYC,
  parameter int PIN_CYC = PIN_MIN_CYC,
  parameter int SUP_CYC = SUPPLY_MIN_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic RST_PIN_N,
  input wire logic RST_PIN_DIS_FUSE,
  input wire logic DEBUG_EN_FUSE,
  input wire logic OSC_OUT_FUSE,
  input wire logic SUPPLY_MON_EN,
  input wire logic SUPPLY_LOW,
  input wire logic USB_EN,
  input wire logic USB_RST_CORE_EN,
  input wire logic USB_BUS_RESET,
  input wire logic SLOW_OSC_TICK,
  input wire logic [2:0] WDT_DIV_SEL,
  input wire logic [3:0] WDT_PERIOD_SEL,
  input wire logic WDT_EN,
  input wire logic WDT_RST_MODE,
  input wire logic WDT_KICK,
  input wire logic ACMP_IN_USE,
  input wire port_ctl_s PORT_C_CTL,
  input wire port_ctl_s PORT_D_CTL,
  output logic CORE_RST,
  output logic SUPPLY_FAULT,
  output logic WDT_EARLY_WARN,
  output logic WDT_IRQ,
  output logic WDT_RST_PULSE,
  output pin_mode_e RST_PIN_MODE,
  output logic OSC_AMP_EN,
  output port_pad_s PORT_C_PAD,
  output port_pad_s PORT_D_PAD
);
  // ----------------------------------------
  // pin function select
  // ----------------------------------------
  always_comb begin
    if (DEBUG_EN_FUSE) begin
      RST_PIN_MODE = PIN_DEBUG;
    end else if (RST_PIN_DIS_FUSE) begin
      RST_PIN_MODE = PIN_GPIO;
    end else begin
      RST_PIN_MODE = PIN_RESET;
    end
  end

  assign OSC_AMP_EN = OSC_OUT_FUSE;

  // ----------------------------------------
  // reset pin filter
  // ----------------------------------------
  logic pin_low;
  logic [15:0] pin_cnt_r;
  logic pin_fault;
  assign pin_low = (RST_PIN_MODE == PIN_RESET) && !RST_PIN_N;
  always_ff @(posedge CLK_SYS) begin
    if (RST || !pin_low) begin
      pin_cnt_r <= 16'h0000;
    end else if (pin_cnt_r != 16'(PIN_CYC)) begin
      pin_cnt_r <= pin_cnt_r + 16'h0001;
    end
  end
  assign pin_fault = pin_low && (pin_cnt_r == 16'(PIN_CYC));

  // ----------------------------------------
  // supply drop filter
  // ----------------------------------------
  logic sup_low;
  logic [15:0] sup_cnt_r;
  assign sup_low = SUPPLY_MON_EN && SUPPLY_LOW;
  always_ff @(posedge CLK_SYS) begin
    if (RST || !sup_low) begin
      sup_cnt_r <= 16'h0000;
    end else if (sup_cnt_r != 16'(SUP_CYC)) begin
      sup_cnt_r <= sup_cnt_r + 16'h0001;
    end
  end
  assign SUPPLY_FAULT = sup_low && (sup_cnt_r == 16'(SUP_CYC));

  // ----------------------------------------
  // watchdog count clock
  // ----------------------------------------
  logic [3:0] div_cnt_r;
  logic wdt_tick;
  always_ff @(posedge CLK_SYS) begin
    if (RST || WDT_DIV_SEL != WDT_DIV_SLOW) begin
      div_cnt_r <= 4'h0;
    end else if (SLOW_OSC_TICK) begin
      if (div_cnt_r == WDT_DIV_SLOW_TOP) begin
        div_cnt_r <= 4'h0;
      end else begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end
  assign wdt_tick = SLOW_OSC_TICK &&
    (WDT_DIV_SEL != WDT_DIV_SLOW ||
     div_cnt_r == WDT_DIV_SLOW_TOP);

  // ----------------------------------------
  // watchdog time-out
  // ----------------------------------------
  logic [WDT_CNT_W-1:0] wdt_cnt_r;
  logic [WDT_CNT_W-1:0] wdt_cnt_nxt;
  logic [WDT_CNT_W-1:0] wdt_lim;
  logic wdt_valid;
  logic wdt_expire;
  assign wdt_valid = WDT_EN && (WDT_PERIOD_SEL <= WDT_SEL_MAX);
  assign wdt_lim = WDT_BASE_CYC << WDT_PERIOD_SEL;
  assign wdt_cnt_nxt = wdt_cnt_r + 22'h000001;
  assign wdt_expire = wdt_valid && wdt_tick &&
    (wdt_cnt_nxt == (wdt_lim << 1));
  always_ff @(posedge CLK_SYS) begin
    if (RST || !wdt_valid || WDT_KICK || wdt_expire) begin
      wdt_cnt_r <= '0;
    end else if (wdt_tick) begin
      wdt_cnt_r <= wdt_cnt_nxt;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WDT_EARLY_WARN <= 1'b0;
    end else begin
      WDT_EARLY_WARN <= wdt_valid && !WDT_KICK && wdt_tick &&
        (wdt_cnt_nxt == wdt_lim);
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WDT_RST_PULSE <= 1'b0;
      WDT_IRQ <= 1'b0;
    end else begin
      WDT_RST_PULSE <= wdt_expire && !WDT_KICK && WDT_RST_MODE;
      WDT_IRQ <= wdt_expire && !WDT_KICK && !WDT_RST_MODE;
    end
  end

  // ----------------------------------------
  // combined reset and release delay
  // ----------------------------------------
  logic usb_rst;
  logic src_any;
  logic [15:0] rel_cnt_r;
  logic rel_busy;
  assign usb_rst = USB_EN && USB_RST_CORE_EN && USB_BUS_RESET;
  assign src_any = RST || pin_fault || SUPPLY_FAULT ||
    WDT_RST_PULSE || usb_rst;
  always_ff @(posedge CLK_SYS) begin
    if (src_any) begin
      rel_cnt_r <= 16'h0000;
    end else if (rel_cnt_r != 16'(REL_CYC)) begin
      rel_cnt_r <= rel_cnt_r + 16'h0001;
    end
  end
  assign rel_busy = rel_cnt_r != 16'(REL_CYC);
  assign CORE_RST = src_any || rel_busy;

  // ----------------------------------------
  // port pads
  // ----------------------------------------
  logic pads_off;
  logic [PORT_W-1:0] c_gpio;
  logic [PORT_W-1:0] d_gpio;
  assign pads_off = CORE_RST || pin_low || sup_low;
  always_comb begin
    c_gpio = '1;
    c_gpio[OSC_PIN_BIT] = !OSC_OUT_FUSE;
    c_gpio[RST_PIN_BIT] = RST_PIN_MODE == PIN_GPIO;
    d_gpio = '1;
    d_gpio[ACMP_BIT_HI:ACMP_BIT_LO] = {2{!ACMP_IN_USE}};
  end
  generate
    for (genvar i = 0; i < PORT_W; i++) begin : g_bit
      logic c_out_r;
      logic d_out_r;
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          c_out_r <= 1'b0;
          d_out_r <= 1'b0;
        end else begin
          c_out_r <= PORT_C_CTL.data[i];
          d_out_r <= PORT_D_CTL.data[i];
        end
      end
      assign PORT_C_PAD.out[i] = c_out_r;
      assign PORT_D_PAD.out[i] = d_out_r;
      assign PORT_C_PAD.oe_n[i] =
        pads_off || !c_gpio[i] || !PORT_C_CTL.dir[i];
      assign PORT_D_PAD.oe_n[i] =
        pads_off || !d_gpio[i] || !PORT_D_CTL.dir[i];
      assign PORT_C_PAD.pull_en[i] = !pads_off && c_gpio[i] &&
        !PORT_C_CTL.dir[i] && PORT_C_CTL.pull[i];
      assign PORT_D_PAD.pull_en[i] = !pads_off && d_gpio[i] &&
        !PORT_D_CTL.dir[i] && PORT_D_CTL.pull[i];
    end
  endgenerate

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_wdt_pulse_one: assert property (
    WDT_RST_PULSE |=> !WDT_RST_PULSE)
    else $error("watchdog reset pulse longer than one cycle");
  a_wdt_rel_start: assert property (
    $fell(WDT_RST_PULSE) && !src_any |-> rel_cnt_r == 16'h0000)
    else $error("release delay did not start after pulse");
  a_sup_fault_now: assert property (
    SUPPLY_FAULT |-> CORE_RST && PORT_C_PAD.oe_n == '1)
    else $error("supply fault did not reset at once");
  a_sup_release: assert property (
    $fell(SUPPLY_FAULT) && !src_any |-> CORE_RST [*8])
    else $error("core released too soon after supply fault");
  a_sup_dip_short: assert property (
    $rose(sup_low) |-> !SUPPLY_FAULT [*2])
    else $error("short supply dip caused fault");
  a_pin_filter: assert property (
    $rose(pin_low) |-> !pin_fault [*2])
    else $error("short reset pin pulse caused reset");
  a_pads_tristate: assert property (
    CORE_RST |-> PORT_C_PAD.oe_n == '1 && PORT_D_PAD.oe_n == '1)
    else $error("port driven during reset");
  a_pin_mode_sel: assert property (
    DEBUG_EN_FUSE |-> RST_PIN_MODE == PIN_DEBUG && !pin_fault)
    else $error("reset pin mode wrong");
  a_usb_reset: assert property (
    usb_rst |-> CORE_RST ##1 rel_cnt_r == 16'h0000)
    else $error("usb bus reset ignored");
  a_wdt_warn_half: assert property (
    WDT_EARLY_WARN |-> !WDT_RST_PULSE && !WDT_IRQ)
    else $error("warning and action coincide");
  a_wdt_reserved: assert property (
    WDT_PERIOD_SEL > WDT_SEL_MAX |=> !WDT_RST_PULSE && !WDT_IRQ)
    else $error("reserved period code timed out");
  a_wdt_div_slow: assert property (
    WDT_DIV_SEL == WDT_DIV_SLOW && wdt_tick
      |-> div_cnt_r == WDT_DIV_SLOW_TOP)
    else $error("slow divider tick misplaced");
  a_osc_pin_gpio: assert property (
    OSC_OUT_FUSE |-> PORT_C_PAD.oe_n[OSC_PIN_BIT])
    else $error("osc pin driven while amplifier fused");
  a_acmp_pins: assert property (
    ACMP_IN_USE |-> PORT_D_PAD.oe_n[ACMP_BIT_HI:ACMP_BIT_LO] == 2'b11)
    else $error("comparator pins driven while in use");
  a_pull_gate: assert property (
    CORE_RST |-> PORT_C_PAD.pull_en == '0 && PORT_D_PAD.pull_en == '0)
    else $error("pull-up on during reset");
  a_release_hold: assert property (
    rel_busy |-> CORE_RST)
    else $error("core released before delay end");

  // ----------------------------------------
  // watchdog checks
  // ----------------------------------------
  a_wdt_warn_one: assert property (
    WDT_EARLY_WARN |=> !WDT_EARLY_WARN)
    else $error("early warning longer than one cycle");
  a_wdt_irq_mode: assert property (
    WDT_IRQ |-> !$past(WDT_RST_MODE))
    else $error("watchdog interrupt in reset mode");
  a_wdt_pulse_rel: assert property (
    WDT_RST_PULSE |=> CORE_RST && rel_cnt_r == 16'h0000)
    else $error("release delay not restarted by watchdog");
  a_wdt_kick_clear: assert property (
    WDT_KICK |=> wdt_cnt_r == '0 && !WDT_RST_PULSE && !WDT_IRQ)
    else $error("kick did not clear the watchdog");
  a_wdt_off_quiet: assert property (
    !WDT_EN |=> !WDT_EARLY_WARN && !WDT_RST_PULSE && !WDT_IRQ)
    else $error("stopped watchdog raised an event");
  a_rel_restart: assert property (
    src_any |=> rel_cnt_r == 16'h0000)
    else $error("reset source did not restart release delay");

  // ----------------------------------------
  // pin and pad checks
  // ----------------------------------------
  a_pin_mode_gate: assert property (
    RST_PIN_MODE != PIN_RESET |-> !pin_low && !pin_fault)
    else $error("reset pin filtered outside reset mode");
  a_rst_pin_pad: assert property (
    RST_PIN_MODE != PIN_GPIO |-> PORT_C_PAD.oe_n[RST_PIN_BIT])
    else $error("reset pin driven outside gpio mode");
  a_sup_mon_off: assert property (
    !SUPPLY_MON_EN |-> !SUPPLY_FAULT)
    else $error("supply fault while monitor disabled");
  a_raw_low_pads: assert property (
    pin_low || sup_low |-> PORT_C_PAD.oe_n == '1 && PORT_D_PAD.oe_n == '1)
    else $error("port driven while a reset source is low");
  a_acmp_pull: assert property (
    ACMP_IN_USE |-> PORT_D_PAD.pull_en[ACMP_BIT_HI:ACMP_BIT_LO] == 2'h0)
    else $error("pull-up on comparator pins in use");
  a_pull_input_only: assert property (
    (PORT_C_PAD.pull_en & PORT_C_CTL.dir) == '0)
    else $error("pull-up on an output bit");
  a_osc_pull: assert property (
    OSC_OUT_FUSE |-> !PORT_C_PAD.pull_en[OSC_PIN_BIT])
    else $error("pull-up on oscillator output pin");
endmodule

// File: logic/rst_seq_pkg.sv
// constants and carrier types for the reset sequencer
// assumes one 25 MHz system clock and synchronous inputs
package rst_seq_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int PIN_MIN_PULSE_NS = 2500;
  localparam int PIN_MIN_CYC =
    (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_SUPPLY_DROP_NS = 2000;
  localparam int SUPPLY_MIN_CYC =
    (MIN_SUPPLY_DROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_DELAY_US = 65;
  localparam int RELEASE_CYC =
    RELEASE_DELAY_US * 1000 / CLK_PERIOD_NS;
  // ----------------------------------------
  // watchdog and port bit layout
  // ----------------------------------------
  localparam int WDT_CNT_W = 22;
  localparam logic [WDT_CNT_W-1:0] WDT_BASE_CYC = 22'h000800;
  localparam logic [3:0] WDT_SEL_MAX = 4'h9;
  localparam logic [2:0] WDT_DIV_SLOW = 3'h5;
  localparam logic [3:0] WDT_DIV_SLOW_TOP = 4'ha;
  localparam int PORT_W = 8;
  localparam int OSC_PIN_BIT = 0;
  localparam int RST_PIN_BIT = 1;
  localparam int ACMP_BIT_LO = 1;
  localparam int ACMP_BIT_HI = 2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PIN_RESET = 2'b00,
    PIN_DEBUG = 2'b01,
    PIN_GPIO = 2'b10
  } pin_mode_e;
  typedef struct packed {
    logic [PORT_W-1:0] dir;
    logic [PORT_W-1:0] data;
    logic [PORT_W-1:0] pull;
  } port_ctl_s;
  typedef struct packed {
    logic [PORT_W-1:0] out;
    logic [PORT_W-1:0] oe_n;
    logic [PORT_W-1:0] pull_en;
  } port_pad_s;
endpackage
